// *** rtl/pts_pkg.sv ***
// Constants shared by the period timer and its scalers.
// Assumes one clock, MCLK, standing in for the instruction clock.
package pts_pkg;
  // Register indices; the byte address is four times the index
  localparam int IDX_FLAGS = 'h0C;
  localparam int IDX_COUNT = 'h11;
  localparam int IDX_CTRL = 'h12;
  localparam int IDX_ENABLES = 'h8C;
  localparam int IDX_PERIOD = 'h92;
  localparam int ADDR_W = 10;
  localparam int WORD_BYTES = 4;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = ADDR_W'(IDX_FLAGS * WORD_BYTES);
  localparam logic [ADDR_W-1:0] ADDR_COUNT = ADDR_W'(IDX_COUNT * WORD_BYTES);
  localparam logic [ADDR_W-1:0] ADDR_CTRL = ADDR_W'(IDX_CTRL * WORD_BYTES);
  localparam logic [ADDR_W-1:0] ADDR_ENABLES = ADDR_W'(IDX_ENABLES * WORD_BYTES);
  localparam logic [ADDR_W-1:0] ADDR_PERIOD = ADDR_W'(IDX_PERIOD * WORD_BYTES);
  localparam logic [1:0] ADDR_LANE_ZERO = 2'h0;

  // Reset values
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [6:0] RST_CTRL = 7'h00;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic RST_FLAG = 1'b0;

  // Control field positions
  localparam int CTL_PRE_LSB = 0;
  localparam int CTL_PRE_MSB = 1;
  localparam int CTL_RUN_BIT = 2;
  localparam int CTL_POST_LSB = 3;
  localparam int CTL_POST_MSB = 6;
  localparam int CTL_IMPL_MSB = 6;
  localparam int FLAG_MATCH_BIT = 1;
  localparam int EN_MATCH_BIT = 1;

  // Scaler terminal counts (ratio minus one)
  localparam int SCL_W = 4;
  localparam logic [SCL_W-1:0] PRE_LIM_DIV1 = 4'h0;
  localparam logic [SCL_W-1:0] PRE_LIM_DIV4 = 4'h3;
  localparam logic [SCL_W-1:0] PRE_LIM_DIV16 = 4'hF;
  localparam logic [1:0] PRE_SEL_DIV1 = 2'h0;
  localparam logic [1:0] PRE_SEL_DIV4 = 2'h1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** rtl/pts_scl_if.sv ***
// Carrier between the timer core and one divide-by-N scaler.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface pts_scl_if #(parameter int W = 4);
  logic clr;
  logic step;
  logic [W-1:0] limit;
  logic done;
  modport ctrl (output clr, output step, output limit, input done);
  modport scaler (input clr, input step, input limit, output done);
endinterface

// *** rtl/pts_scaler.sv ***
// Divide-by-N event counter used for prescaler and postscaler.
// Assumes clr and step arrive on the same clock; clr wins over step in the count, but done is not gated by clr.
`timescale 1ns/100ps
module pts_scaler #(
  parameter int W = 4
) (
  input wire logic clk,
  pts_scl_if.scaler sc
);
  logic [W-1:0] cnt_reg;

  // Count steps, wrap at the limit
  always_ff @(posedge clk) begin
    if (sc.clr) begin
      cnt_reg <= '0;
    end else if (sc.step) begin
      if (cnt_reg == sc.limit) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  // Completion on the step taken at the limit, which wraps the count
  assign sc.done = sc.step && (cnt_reg == sc.limit);
endmodule

// *** rtl/pts_timer.sv ***
// Eight-bit period timer with prescaler, postscaler and AXI4-Lite
// register slave.
// Assumes MCLK is the instruction clock (oscillator divided by four)
// and that SYS_RST covers every reset cause of the device.
//
// Notes on behaviour
// RQ1: Count from zero, wrap to zero after period
// RQ2: Period resets to all ones, software accessible
// RQ3: Prescaler divides by one, four or sixteen
// RQ4: Postscaler ratio is select field plus one
// RQ5: Postscaler completion sets the match flag
// RQ6: Count/control writes and reset clear scalers
// RQ7: Control write leaves the count untouched
// RQ8: Count readable, writable, cleared by reset
// RQ9: Run bit starts and stops counting
// RQ10: Raw match pulse goes to serial port
// RQ11: Count and match feed the PWM unit
// RQ12: Control bit seven ignores writes, reads zero
// RQ13: Interrupt while flag and enable both set
// RQ14: Software clears flag by writing zero
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
module pts_timer
  import pts_pkg::*;
(
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic [pts_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [pts_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic IRQ,
  output logic SSP_SHIFT_TICK,
  output logic [7:0] PWM_COUNT,
  output logic PWM_MATCH
);
  import pts_pkg::*;

  // Register state
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [7:0] period_reg;
  logic [CTL_IMPL_MSB:0] ctrl_reg;
  logic [7:0] enables_reg;
  logic flag_reg;
  logic flag_next;
  logic match_reg;

  // Bus slave state
  logic aw_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;

  // Decoded strobes
  logic wr_fire;
  logic wr_lane0;
  logic wr_mapped;
  logic wr_count;
  logic wr_ctrl;
  logic wr_period;
  logic wr_flags;
  logic wr_enables;
  logic rd_fire;
  logic [7:0] rd_byte;
  logic rd_mapped;

  // Timer events
  logic run;
  logic tick;
  logic at_period;
  logic match;
  logic scl_clr;

  pts_scl_if #(.W(SCL_W)) pre_if ();
  pts_scl_if #(.W(SCL_W)) post_if ();

  pts_scaler #(.W(SCL_W)) u_prescaler (
    .clk(MCLK),
    .sc(pre_if.scaler)
  );

  pts_scaler #(.W(SCL_W)) u_postscaler (
    .clk(MCLK),
    .sc(post_if.scaler)
  );

  // Write channel handshakes
  assign S_AXI_AWREADY = !aw_held_reg;
  assign S_AXI_WREADY = !w_held_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_lane0 = w_strb_reg[0];

  // Write address decode
  always_comb begin
    wr_count = 1'b0;
    wr_ctrl = 1'b0;
    wr_period = 1'b0;
    wr_flags = 1'b0;
    wr_enables = 1'b0;
    wr_mapped = 1'b1;
    unique case (aw_addr_reg)
      ADDR_COUNT: wr_count = wr_fire && wr_lane0;
      ADDR_CTRL: wr_ctrl = wr_fire && wr_lane0;
      ADDR_PERIOD: wr_period = wr_fire && wr_lane0;
      ADDR_FLAGS: wr_flags = wr_fire && wr_lane0;
      ADDR_ENABLES: wr_enables = wr_fire && wr_lane0;
      default: wr_mapped = 1'b0;
    endcase
  end

  // Capture write address
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (S_AXI_AWVALID && !aw_held_reg) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  // Capture write data
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (S_AXI_WVALID && !w_held_reg) begin
      w_held_reg <= 1'b1;
      w_data_reg <= S_AXI_WDATA;
      w_strb_reg <= S_AXI_WSTRB;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read channel
  assign S_AXI_ARREADY = !rvalid_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RRESP = rresp_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign rd_fire = S_AXI_ARVALID && !rvalid_reg;

  // Read mux, upper bits zero
  always_comb begin
    rd_byte = 8'h00;
    rd_mapped = 1'b1;
    unique case (S_AXI_ARADDR)
      ADDR_COUNT: rd_byte = count_reg; // [RQ8]
      ADDR_CTRL: rd_byte = {1'b0, ctrl_reg}; // [RQ12]
      ADDR_PERIOD: rd_byte = period_reg; // [RQ2]
      ADDR_FLAGS: rd_byte[FLAG_MATCH_BIT] = flag_reg;
      ADDR_ENABLES: rd_byte = enables_reg;
      default: rd_mapped = 1'b0;
    endcase
  end

  // Read data and response
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      rdata_reg <= {24'h000000, rd_byte};
    end else if (S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Prescaler drive
  assign run = ctrl_reg[CTL_RUN_BIT]; // [RQ9]
  assign scl_clr = SYS_RST || wr_count || wr_ctrl; // [RQ6]
  assign pre_if.clr = scl_clr;
  assign pre_if.step = run; // [RQ9]
  always_comb begin
    unique case (ctrl_reg[CTL_PRE_MSB:CTL_PRE_LSB])
      PRE_SEL_DIV1: pre_if.limit = PRE_LIM_DIV1; // [RQ3]
      PRE_SEL_DIV4: pre_if.limit = PRE_LIM_DIV4; // [RQ3]
      default: pre_if.limit = PRE_LIM_DIV16; // [RQ3]
    endcase
  end
  assign tick = pre_if.done && !scl_clr;

  // Period match
  assign at_period = (count_reg == period_reg);
  assign match = tick && at_period; // [RQ1]

  // Postscaler drive
  assign post_if.clr = scl_clr;
  assign post_if.step = match;
  assign post_if.limit = ctrl_reg[CTL_POST_MSB:CTL_POST_LSB]; // [RQ4]

  // Next count, software write wins over tick
  always_comb begin
    count_next = count_reg;
    if (wr_count) begin
      count_next = w_data_reg[7:0]; // [RQ8]
    end else if (match) begin
      count_next = RST_COUNT; // [RQ1]
    end else if (tick) begin
      count_next = count_reg + 8'h01; // [RQ1]
    end
  end

  // Count register
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      count_reg <= RST_COUNT; // [RQ8]
    end else begin
      count_reg <= count_next; // [RQ7]
    end
  end

  // Period register
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      period_reg <= RST_PERIOD; // [RQ2]
    end else if (wr_period) begin
      period_reg <= w_data_reg[7:0]; // [RQ2]
    end
  end

  // Control register, top bit not stored
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ctrl_reg <= RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_reg <= w_data_reg[CTL_IMPL_MSB:0]; // [RQ12]
    end
  end

  // Interrupt enables
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      enables_reg <= RST_ENABLES;
    end else if (wr_enables) begin
      enables_reg <= w_data_reg[7:0];
    end
  end

  // Match flag, hardware set beats software clear
  always_comb begin
    flag_next = flag_reg;
    if (post_if.done) begin
      flag_next = 1'b1; // [RQ5]
    end else if (wr_flags) begin
      flag_next = w_data_reg[FLAG_MATCH_BIT]; // [RQ14]
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      flag_reg <= RST_FLAG;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // Registered match pulse for peers
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      match_reg <= 1'b0;
    end else begin
      match_reg <= match; // [RQ10]
    end
  end

  // Outputs to serial port, PWM and interrupt line
  assign SSP_SHIFT_TICK = match_reg; // [RQ10]
  assign PWM_MATCH = match_reg; // [RQ11]
  assign PWM_COUNT = count_reg; // [RQ11]
  assign IRQ = flag_reg && enables_reg[EN_MATCH_BIT]; // [RQ13]
endmodule

// *** bench/pts_chk.sv ***
// Port checker for the period timer.
// Assumes it is bound to pts_timer.
`timescale 1ns/100ps
module pts_chk
  import pts_pkg::*;
(
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic [pts_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic IRQ,
  input wire logic SSP_SHIFT_TICK,
  input wire logic PWM_MATCH
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // Bus handshakes
  sequence s_wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_rd_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  a_match_outs_agree: assert property (PWM_MATCH == SSP_SHIFT_TICK)
    else $error("match outputs differ");
  a_irq_rise_match: assert property ($rose(IRQ) && !$rose(S_AXI_BVALID) |-> SSP_SHIFT_TICK)
    else $error("irq rose without match");
  a_irq_fall_write: assert property ($fell(IRQ) |-> $rose(S_AXI_BVALID))
    else $error("irq fell without write");
  a_ctrl_top_zero: assert property (s_rd_taken ##0 S_AXI_ARADDR == ADDR_CTRL |=> !S_AXI_RDATA[7])
    else $error("control bit 7 read as one");
  a_rdata_upper_zero: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_rd_answer_next: assert property (s_rd_taken |=> S_AXI_RVALID)
    else $error("read answer late");
  a_wr_answer_two: assert property (s_wr_taken |-> ##2 S_AXI_BVALID && S_AXI_AWREADY)
    else $error("write answer late");
  a_rd_busy_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read accepted while busy");
endmodule
bind pts_timer pts_chk chk (.MCLK, .SYS_RST, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
  .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
  .S_AXI_BVALID, .IRQ, .SSP_SHIFT_TICK, .PWM_MATCH);

// *** bench/tb_pts_timer.sv ***
// Self-checking bench for the period timer.
// Assumes package, scaler and timer are compiled first.
`timescale 1ns/100ps
module tb_pts_timer
  import pts_pkg::*;
;
  logic MCLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [ADDR_W-1:0] S_AXI_AWADDR = 10'h000;
  logic [ADDR_W-1:0] S_AXI_ARADDR = 10'h000;
  logic [31:0] S_AXI_WDATA = 32'h00000000;
  logic [3:0] S_AXI_WSTRB = 4'h0;
  logic S_AXI_AWVALID = 1'b0;
  logic S_AXI_WVALID = 1'b0;
  logic S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0;
  logic S_AXI_RREADY = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0] S_AXI_RDATA;
  logic IRQ, SSP_SHIFT_TICK, PWM_MATCH;
  logic [7:0] PWM_COUNT;
  int err_total = 0;
  int n_checks = 0;
  int n;
  // Clock
  always #10 MCLK = ~MCLK;
  pts_timer uut (.MCLK, .SYS_RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
    .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
    .S_AXI_RREADY, .IRQ, .SSP_SHIFT_TICK, .PWM_COUNT, .PWM_MATCH);
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bus write, response checked
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic ha, hw, b;
    logic [1:0] r;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h000000, d};
    S_AXI_WSTRB <= s;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(negedge MCLK);
      ha = S_AXI_AWVALID && S_AXI_AWREADY;
      hw = S_AXI_WVALID && S_AXI_WREADY;
      b = S_AXI_BVALID;
      r = S_AXI_BRESP;
      @(posedge MCLK);
      if (ha) S_AXI_AWVALID <= 1'b0;
      if (hw) S_AXI_WVALID <= 1'b0;
    end while (b !== 1'b1);
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask
  // Bus read, data and response checked
  task automatic rd(input logic [9:0] a, input logic [7:0] e, input logic [1:0] er);
    logic h, v;
    logic [31:0] d;
    logic [1:0] r;
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(negedge MCLK);
      h = S_AXI_ARVALID && S_AXI_ARREADY;
      v = S_AXI_RVALID;
      d = S_AXI_RDATA;
      r = S_AXI_RRESP;
      @(posedge MCLK);
      if (h) S_AXI_ARVALID <= 1'b0;
    end while (v !== 1'b1);
    chk($sformatf("rdata %h", a), {24'h000000, e}, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask
  // Cycles between two match pulses
  task automatic gap(output int c);
    c = 0;
    do @(negedge MCLK); while (SSP_SHIFT_TICK !== 1'b1);
    do begin
      @(negedge MCLK);
      c++;
    end while (SSP_SHIFT_TICK !== 1'b1);
    @(posedge MCLK);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000;
    err_total++;
    print_verdict;
  end
  // Test sequence
  initial begin
    repeat (16) @(posedge MCLK);
    SYS_RST <= 1'b0;
    @(posedge MCLK);
    rd(ADDR_FLAGS, 8'h00, RESP_OKAY);
    rd(ADDR_COUNT, 8'h00, RESP_OKAY);
    rd(ADDR_CTRL, 8'h00, RESP_OKAY);
    rd(ADDR_ENABLES, 8'h00, RESP_OKAY);
    rd(ADDR_PERIOD, 8'hFF, RESP_OKAY);
    rd(10'h3FC, 8'h00, RESP_SLVERR);
    wr(10'h3FC, 8'h11, 4'h1, RESP_SLVERR);
    wr(ADDR_PERIOD, 8'h3C, 4'h0, RESP_OKAY);
    rd(ADDR_PERIOD, 8'hFF, RESP_OKAY);
    $display("test reset done");
    wr(ADDR_COUNT, 8'h5A, 4'h1, RESP_OKAY);
    wr(ADDR_CTRL, 8'hF8, 4'h1, RESP_OKAY);
    rd(ADDR_CTRL, 8'h78, RESP_OKAY);
    rd(ADDR_COUNT, 8'h5A, RESP_OKAY);
    $display("test control done");
    wr(ADDR_PERIOD, 8'h02, 4'h1, RESP_OKAY);
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_CTRL, {6'h01, 2'(p)}, 4'h1, RESP_OKAY);
      gap(n);
      chk("spacing", 32'(3 * ((p == 0) ? 1 : (p == 1) ? 4 : 16)), 32'(n));
    end
    $display("test prescale done");
    wr(ADDR_ENABLES, 8'h02, 4'h1, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL, 8'h00, 4'h1, RESP_OKAY);
      wr(ADDR_FLAGS, 8'h00, 4'h1, RESP_OKAY);
      wr(ADDR_COUNT, 8'h00, 4'h1, RESP_OKAY);
      chk("irq idle", 32'h0, {31'h0, IRQ});
      wr(ADDR_CTRL, {1'b0, 4'(i * i * 2 - i), 3'b100}, 4'h1, RESP_OKAY);
      n = 0;
      do begin
        @(negedge MCLK);
        if (IRQ !== 1'b1 && SSP_SHIFT_TICK === 1'b1) n++;
      end while (IRQ !== 1'b1);
      @(posedge MCLK);
      chk("matches", 32'(i * i * 2 - i), 32'(n));
    end
    wr(ADDR_CTRL, 8'h00, 4'h1, RESP_OKAY);
    wr(ADDR_ENABLES, 8'h00, 4'h1, RESP_OKAY);
    chk("irq masked", 32'h0, {31'h0, IRQ});
    rd(ADDR_FLAGS, 8'h02, RESP_OKAY);
    wr(ADDR_FLAGS, 8'h00, 4'h1, RESP_OKAY);
    rd(ADDR_FLAGS, 8'h00, RESP_OKAY);
    wr(ADDR_COUNT, 8'h01, 4'h1, RESP_OKAY);
    repeat (20) @(posedge MCLK);
    @(negedge MCLK);
    chk("pwm count", 32'h00000001, {24'h000000, PWM_COUNT});
    @(posedge MCLK);
    rd(ADDR_COUNT, 8'h01, RESP_OKAY);
    $display("test postscale done");
    print_verdict;
  end
endmodule
